// ---- flash_self_program_ctrl_bench.sv ----
// Purpose: Self-checking bench for fsp_ctrl
// Assumes: Short write time via PROG_CYCLES
// Notes: Read and load results are checked from queues by a watcher
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_ctrl_bench;
    logic hclk = 0, hresetn = 0, por_n = 0, ce = 1, hsel = 0, hwrite = 0, dbusy = 0, rph = 0;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, st = 32'd47566, hrdata, qr[$], ql[$];
    logic hready, hreadyout, hresp, load_valid, cpu_halt, nvm_busy, nvm_erase, store_instr, load_instr, la, lb;
    logic [15:0] pointer_in, store_word, flash_rword, nvm_rd_word, bwd[4];
    logic [7:0] load_data, fl, fh, fe, cal, tof, tg, fv[4], sv[7];
    logic [fsp_pkg::PAGE_W-1:0] nvm_page;
    logic [5:0] ridx = 0;
    int bad_count = 0, n_tests = 0, cyc = 0;
    localparam logic [31:0] CTL = fsp_pkg::OFS_CTL;
    always #20 hclk = ~hclk;
    assign hready = hreadyout;
    fsp_ctrl #(.PROG_CYCLES(17'd20), .ID_BYTE0(8'h5c), .ID_BYTE1(8'h6d), .ID_BYTE2(8'h7e)) u_fsp_ctrl (
        .hclk, .hresetn, .por_n, .ce, .hsel, .haddr, .hwrite, .hsize, .htrans, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .store_instr, .load_instr, .pointer_in, .store_word, .flash_rword, .load_data,
        .load_valid, .cpu_halt, .data_nvm_write_busy(dbusy), .fuse_low_value(fl), .fuse_high_value(fh),
        .fuse_extended_value(fe), .protection_bit_a(la), .protection_bit_b(lb), .osc_cal_byte(cal),
        .temperature_offset_byte(tof), .temperature_gain_byte(tg), .nvm_busy, .nvm_erase, .nvm_page,
        .nvm_rd_idx(ridx), .nvm_rd_word);
    fsp_core_model u_fsp_core_model (.hclk, .store_instr, .load_instr, .pointer_in, .store_word, .flash_rword);
    // ==========================================================
    // Tasks
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction : rnd
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task close_out();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task bw(input logic [31:0] a, input logic [31:0] d, input logic w);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : bw
    task wr(input logic [5:0] lo, input logic [1:0] hi = 2'h0);
        bw(CTL, {24'h0, hi, lo}, 1);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] e);
        qr.push_back(e);
        bw(a, rnd(), 0);
    endtask : rd
    task ld(input int d, input logic [15:0] p, input logic [15:0] w, input logic [7:0] e);
        ql.push_back({24'h0, e});
        u_fsp_core_model.op(d, 0, 1, p, w);
    endtask : ld
    task bchk(input logic [5:0] i, input logic [15:0] e);
        @(posedge hclk);
        ridx <= i;
        @(posedge hclk);
        @(negedge hclk);
        chk("buffer", 32'(e), 32'(nvm_rd_word));
        @(posedge hclk);
    endtask : bchk
    // ==========================================================
    // Watcher and timeout
    always @(posedge hclk) begin
        if (++cyc > 20000) begin
            bad_count++;
            close_out();
        end
        if (load_valid === 1'b1) chk("load_data", ql.size() > 0 ? ql.pop_front() : 'x, 32'(load_data));
        if (rph) chk("hrdata", qr.size() > 0 ? qr.pop_front() : 'x, hrdata);
        rph = hsel && htrans[1] && !hwrite && hready;
    end
    // ==========================================================
    // Main sequence
    initial begin
        int i;
        logic [31:0] v, w;
        logic [fsp_pkg::PAGE_W-1:0] pg;
        v = rnd();
        {cal, fe, fh, fl} = v;
        v = rnd();
        {la, lb, tg, tof} = v[17:0];
        pg = v[30:22];
        fv = '{fl, {6'h3f, lb, la}, fe, fh};
        sv = '{8'h5c, cal, 8'h6d, tof, 8'h7e, tg, 8'h00};
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        por_n <= 1;
        @(posedge hclk);
        rd(CTL, 0);
        rd(32'h40, 0);
        rd(fsp_pkg::OFS_ENG, 0);
        for (i = 0; i < 6; i++) begin
            v = rnd();
            v[0] = 1;
            if ($countones(v[5:1]) < 2) v[5:4] = 2'b11;
            wr(v[5:0], v[7:6]);
            rd(CTL, 0);
        end
        wr(6'h01, 2'h3);
        rd(CTL, 1);
        repeat (3) @(posedge hclk);
        rd(CTL, 0);
        for (i = 0; i < 11; i++) begin
            wr(i < 4 ? fsp_pkg::PAT_FUSE_LOCKBYTE_READ : fsp_pkg::PAT_SIG);
            w = rnd();
            if (i >= 4) u_fsp_core_model.op(1, 1, 0, 16'(i - 4), w[15:0]);
            ld(i < 4 ? 1 + i % 3 : 2, 16'(i < 4 ? i : i - 4), w[15:0], i < 4 ? fv[i] : sv[i - 4]);
            rd(CTL, 0);
        end
        wr(fsp_pkg::PAT_FUSE_LOCKBYTE_READ);
        w = rnd();
        ld(4, 16'h0003, w[15:0], w[15:8]);
        ld(2, 16'h0002, w[15:0], w[7:0]);
        dbusy <= 1;
        wr(fsp_pkg::PAT_FUSE_LOCKBYTE_READ);
        ld(1, 16'h0000, w[15:0], w[7:0]);
        rd(CTL, 0);
        dbusy <= 0;
        for (i = 0; i < 2; i++) begin
            wr(i ? fsp_pkg::PAT_WIPE : fsp_pkg::PAT_PROG);
            repeat (4) @(posedge hclk);
            rd(CTL, 0);
        end
        wr(fsp_pkg::PAT_FILL);
        u_fsp_core_model.op(1, 1, 0, {pg, 6'd9, 1'b1}, w[15:0]);
        bchk(6'd9, w[15:0]);
        wr(fsp_pkg::PAT_CLEAR_PAGE_BUFFER);
        bchk(6'd9, 16'hffff);
        for (i = 0; i < 4; i++) begin
            wr(fsp_pkg::PAT_FILL);
            w = rnd();
            bwd[i] = w[15:0];
            u_fsp_core_model.op(i + 1, 1, 0, {pg, 6'(i * 7), 1'b1}, w[15:0]);
        end
        for (i = 0; i < 4; i++) bchk(6'(i * 7), bwd[i]);
        wr(fsp_pkg::PAT_PROG);
        u_fsp_core_model.op(4, 1, 0, {pg, 7'h55}, w[15:0]);
        rd(CTL, 32'h05);
        repeat (2) @(posedge hclk);
        rd(fsp_pkg::OFS_ENG, {22'h0, pg, 1'b1});
        @(negedge hclk);
        chk("halt", 1, 32'(cpu_halt));
        chk("erase", 0, 32'(nvm_erase));
        chk("page", 32'(pg), 32'(nvm_page));
        @(posedge hclk);
        wr(fsp_pkg::PAT_WIPE);
        rd(CTL, 32'h05);
        do @(negedge hclk); while (nvm_busy !== 1'b0);
        repeat (3) @(posedge hclk);
        rd(CTL, 0);
        @(negedge hclk);
        chk("busy", 0, 32'(nvm_busy));
        bchk(6'd7, 16'hffff);
        pg = pg + 1'b1;
        wr(fsp_pkg::PAT_WIPE);
        u_fsp_core_model.op(4, 1, 0, {pg, 7'h01}, w[15:0]);
        repeat (3) @(posedge hclk);
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        @(negedge hclk);
        chk("busy", 1, 32'(nvm_busy));
        chk("erase", 1, 32'(nvm_erase));
        chk("page", 32'(pg), 32'(nvm_page));
        do @(negedge hclk); while (nvm_busy !== 1'b0);
        repeat (3) @(posedge hclk);
        close_out();
    end
endmodule : flash_self_program_ctrl_bench
`default_nettype wire

// ---- fsp_core_model.sv ----
// Purpose: Core side issuing store and load strobes
// Assumes: Called just after a rising edge
// Notes: Idle lines show inverted data so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
    input wire logic hclk, // Clock
    output logic store_instr, // Store strobe
    output logic load_instr, // Load strobe
    output logic [15:0] pointer_in, // Pointer
    output logic [15:0] store_word, // Store data
    output logic [15:0] flash_rword // Array word
);
    initial begin
        {store_instr, load_instr, pointer_in, store_word, flash_rword} = '0;
    end
    // ==========================================================
    // One-cycle strobe, d cycles after the call edge
    task automatic op(input int d, input logic st, input logic ld, input logic [15:0] p, input logic [15:0] w);
        repeat (d - 1) @(posedge hclk);
        store_instr <= st;
        load_instr <= ld;
        pointer_in <= p;
        store_word <= w;
        flash_rword <= w;
        @(posedge hclk);
        store_instr <= 1'b0;
        load_instr <= 1'b0;
        pointer_in <= ~p;
        store_word <= ~w;
        flash_rword <= ~w;
    endtask : op
endmodule : fsp_core_model
`default_nettype wire

// ---- fsp_ctrl.sv ----
// Purpose: Self-programming control for on-chip program flash
// Assumes: Core strobes and data_nvm_write_busy are on hclk; fuse values are static
// Notes: Page buffer and write timer sit on por_n so a system reset never cuts a write
//
// Implementation choices: the address map and register access over AHB-Lite.

`timescale 1ns/1ps
`default_nettype none

module fsp_ctrl #(
    parameter logic [fsp_pkg::CNT_W-1:0] PROG_CYCLES = fsp_pkg::PROG_CYC,
    parameter logic [7:0] ID_BYTE0 = 8'h11, // Arbitrary value
    parameter logic [7:0] ID_BYTE1 = 8'h22, // Arbitrary value
    parameter logic [7:0] ID_BYTE2 = 8'h33  // Arbitrary value
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // System reset
    input wire logic por_n, // Power-on reset of write engine
    input wire logic ce, // Clock enable
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [1:0] htrans, // Transfer type
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response
    input wire logic store_instr, // Store-to-program pulse
    input wire logic load_instr, // Load-from-program pulse
    input wire logic [15:0] pointer_in, // Pointer high and low byte
    input wire logic [15:0] store_word, // Register pair data
    input wire logic [15:0] flash_rword, // Array word at pointer
    output logic [7:0] load_data, // Load result
    output logic load_valid, // Load result strobe
    output logic cpu_halt, // Core stall
    input wire logic data_nvm_write_busy, // Data memory write busy
    input wire logic [7:0] fuse_low_value, // Low fuse byte
    input wire logic [7:0] fuse_high_value, // High fuse byte
    input wire logic [7:0] fuse_extended_value, // Extended fuse byte
    input wire logic protection_bit_a, // Lock bit a
    input wire logic protection_bit_b, // Lock bit b
    input wire logic [7:0] osc_cal_byte, // Oscillator calibration
    input wire logic [7:0] temperature_offset_byte, // Temp offset
    input wire logic [7:0] temperature_gain_byte, // Temp gain
    output logic nvm_busy, // Array operation running
    output logic nvm_erase, // Operation is erase
    output logic [fsp_pkg::PAGE_W-1:0] nvm_page, // Target page
    input wire logic [fsp_pkg::WORD_BITS-1:0] nvm_rd_idx, // Buffer read index
    output logic [15:0] nvm_rd_word // Buffer word, one cycle after index
);

    fsp_pkg::fsp_core_s q, d;
    fsp_pkg::fsp_eng_s eq, ed;

    logic [7:0] ctl_rd;
    logic [31:0] eng_rd;
    logic armed;
    logic [5:0] pat;
    logic ctl_wr;

    localparam int ENG_PAGE_HI = fsp_pkg::ENG_PAGE_LSB + fsp_pkg::PAGE_W - 1;

    // ==========================================================
    // Register read views
    // ==========================================================
    always_comb begin
        ctl_rd = fsp_pkg::CTL_RESET;
        ctl_rd[fsp_pkg::BIT_SIG] = (q.mode == fsp_pkg::MODE_SIG);
        ctl_rd[fsp_pkg::BIT_FUSE_LOCKBYTE_READ] = (q.mode == fsp_pkg::MODE_FUSE);
        ctl_rd[fsp_pkg::BIT_PAGE_PROGRAM] = (q.mode == fsp_pkg::MODE_PROG);
        ctl_rd[fsp_pkg::BIT_PAGE_WIPE] = (q.mode == fsp_pkg::MODE_WIPE);
        ctl_rd[fsp_pkg::BIT_EN] = (q.mode != fsp_pkg::MODE_IDLE);
        eng_rd = 32'h0000_0000;
        eng_rd[0] = eq.busy;
        eng_rd[ENG_PAGE_HI:fsp_pkg::ENG_PAGE_LSB] = eq.page;
    end

    assign armed = (q.mode != fsp_pkg::MODE_IDLE) && !q.waiting;
    assign pat = hwdata[5:0];
    assign ctl_wr = q.ap_valid && q.ap_write && (q.ap_idx == fsp_pkg::IDX_CTL);

    // ==========================================================
    // Sequencer next state
    // ==========================================================
    always_comb begin
        d = q;
        d.ld_valid = 1'b0;
        d.start = 1'b0;
        d.buf_we = 1'b0;
        d.buf_clr = 1'b0;

        // Window expiry, counted from the control write
        if (armed) begin
            if (q.win == 3'h1) begin
                d.mode = fsp_pkg::MODE_IDLE;
                d.win = 3'h0;
            end else begin
                d.win = q.win - 3'h1;
            end
        end

        // Store-to-program instruction
        if (store_instr && armed && !eq.busy) begin
            unique case (q.mode)
                fsp_pkg::MODE_FILL: begin
                    d.buf_we = 1'b1;
                    d.buf_idx = pointer_in[fsp_pkg::WORD_BITS:1];
                    d.buf_wdata = store_word;
                    d.mode = fsp_pkg::MODE_IDLE;
                end
                fsp_pkg::MODE_CLEAR: begin
                    d.mode = fsp_pkg::MODE_IDLE;
                end
                fsp_pkg::MODE_WIPE, fsp_pkg::MODE_PROG: begin
                    d.start = 1'b1;
                    d.start_erase = (q.mode == fsp_pkg::MODE_WIPE);
                    d.start_page = pointer_in[15:fsp_pkg::WORD_BITS+1];
                    d.waiting = 1'b1;
                    // Store on the last window cycle must not lose the op bits
                    d.mode = q.mode;
                end
                fsp_pkg::MODE_FUSE, fsp_pkg::MODE_SIG: begin
                    // Ignored store; leaves the window running down
                    d.start = 1'b0;
                end
                fsp_pkg::MODE_IDLE: begin
                    d.mode = q.mode;
                end
            endcase
        end

        // Load-from-program instruction
        if (load_instr) begin
            d.ld_valid = 1'b1;
            d.ld_data = pointer_in[0] ? flash_rword[15:8] : flash_rword[7:0];
            if (armed && q.mode == fsp_pkg::MODE_FUSE) begin
                d.mode = fsp_pkg::MODE_IDLE;
                d.win = 3'h0;
                unique case (pointer_in)
                    fsp_pkg::Z_LOCK: d.ld_data = {fsp_pkg::LOCK_PAD, protection_bit_b, protection_bit_a};
                    fsp_pkg::Z_FUSE_LOW: d.ld_data = fuse_low_value;
                    fsp_pkg::Z_FUSE_HIGH: d.ld_data = fuse_high_value;
                    fsp_pkg::Z_FUSE_EXT: d.ld_data = fuse_extended_value;
                    default: d.ld_data = fsp_pkg::RESERVED_BYTE;
                endcase
            end else if (armed && q.mode == fsp_pkg::MODE_SIG) begin
                d.mode = fsp_pkg::MODE_IDLE;
                d.win = 3'h0;
                unique case (pointer_in)
                    fsp_pkg::Z_ID0: d.ld_data = ID_BYTE0;
                    fsp_pkg::Z_CAL: d.ld_data = osc_cal_byte;
                    fsp_pkg::Z_ID1: d.ld_data = ID_BYTE1;
                    fsp_pkg::Z_TOFS: d.ld_data = temperature_offset_byte;
                    fsp_pkg::Z_ID2: d.ld_data = ID_BYTE2;
                    fsp_pkg::Z_TGAIN: d.ld_data = temperature_gain_byte;
                    default: d.ld_data = fsp_pkg::RESERVED_BYTE;
                endcase
            end
        end

        // Array operation finished: enable and op bit drop together
        if (q.waiting && eq.done) begin
            d.waiting = 1'b0;
            d.mode = fsp_pkg::MODE_IDLE;
            d.win = 3'h0;
        end

        // Control write lands in the data phase; only one operation at a time
        if (ctl_wr && !q.waiting && !q.start && !eq.busy && !data_nvm_write_busy) begin
            d.win = fsp_pkg::STORE_WIN;
            unique case (pat)
                fsp_pkg::PAT_FILL: d.mode = fsp_pkg::MODE_FILL;
                fsp_pkg::PAT_CLEAR_PAGE_BUFFER: begin
                    d.mode = fsp_pkg::MODE_CLEAR;
                    d.buf_clr = 1'b1;
                end
                fsp_pkg::PAT_FUSE_LOCKBYTE_READ: begin
                    d.mode = fsp_pkg::MODE_FUSE;
                    d.win = fsp_pkg::LOAD_WIN;
                end
                fsp_pkg::PAT_SIG: begin
                    d.mode = fsp_pkg::MODE_SIG;
                    d.win = fsp_pkg::LOAD_WIN;
                end
                fsp_pkg::PAT_PROG: d.mode = fsp_pkg::MODE_PROG;
                fsp_pkg::PAT_WIPE: d.mode = fsp_pkg::MODE_WIPE;
                default: d.win = q.win;
            endcase
        end

        // Buffer erase after system reset, deferred while a write runs
        if (q.clr_pend && !eq.busy && !q.start) begin
            d.clr_pend = 1'b0;
            d.buf_clr = 1'b1;
        end

        // AHB-Lite address phase; read data registered into the data phase
        if (hsel && htrans[1] && hready) begin
            d.ap_valid = 1'b1;
            d.ap_write = hwrite;
            d.ap_idx = haddr[7:2];
            // Writes leave hrdata at zero in their data phase
            unique case ({!hwrite && haddr[31:8] == 24'h00_0000, haddr[7:2]})
                {1'b1, fsp_pkg::IDX_CTL}: d.rdata = {24'h00_0000, ctl_rd};
                {1'b1, fsp_pkg::IDX_ENG}: d.rdata = eng_rd;
                default: d.rdata = 32'h0000_0000;
            endcase
        end else if (hready) begin
            d.ap_valid = 1'b0;
            d.rdata = 32'h0000_0000;
        end
    end

    // ==========================================================
    // Write engine: timer and page buffer, kept alive over system reset
    // ==========================================================
    always_comb begin
        ed = eq;
        ed.done = 1'b0;
        if (q.buf_we) begin
            ed.buffer[q.buf_idx] = q.buf_wdata;
        end
        if (q.buf_clr) begin
            ed.buffer = {fsp_pkg::PAGE_WORDS{fsp_pkg::BUF_ERASED}};
        end
        if (q.start && !eq.busy) begin
            ed.busy = 1'b1;
            ed.erase = q.start_erase;
            ed.page = q.start_page;
            ed.cnt = PROG_CYCLES - 1'b1;
        end else if (eq.busy) begin
            if (eq.cnt == '0) begin
                ed.busy = 1'b0;
                ed.done = 1'b1;
                if (!eq.erase) begin
                    ed.buffer = {fsp_pkg::PAGE_WORDS{fsp_pkg::BUF_ERASED}};
                end
            end else begin
                ed.cnt = eq.cnt - 1'b1;
            end
        end
        ed.rd_word = eq.buffer[nvm_rd_idx];
    end

    // ==========================================================
    // State registers
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= fsp_pkg::CORE_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // Only power-on clears this; a system reset mid-write lets the timer run out
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            eq <= fsp_pkg::ENG_RST;
        end else if (ce) begin
            eq <= ed;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign load_data = q.ld_data;
    assign load_valid = q.ld_valid;
    assign cpu_halt = q.start | eq.busy;
    assign nvm_busy = eq.busy;
    assign nvm_erase = eq.erase;
    assign nvm_page = eq.page;
    assign nvm_rd_word = eq.rd_word;

endmodule : fsp_ctrl

`default_nettype wire

// ---- fsp_ctrl_monitor.sv ----
// Purpose: Port checks for fsp_ctrl
// Assumes: ce held high
// Notes: Busy counter has no reset, so a system reset cannot hide a long write
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_monitor #(
    parameter logic [fsp_pkg::CNT_W-1:0] PROG_CYCLES = fsp_pkg::PROG_CYC
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic ce, // Enable
    input wire logic hsel, // Select
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic hready, // Ready in
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Ready out
    input wire logic hresp, // Response
    input wire logic store_instr, // Store
    input wire logic load_instr, // Load
    input wire logic [7:0] load_data, // Load data
    input wire logic load_valid, // Load strobe
    input wire logic cpu_halt, // Halt
    input wire logic nvm_busy, // Busy
    input wire logic nvm_erase, // Erase
    input wire logic [fsp_pkg::PAGE_W-1:0] nvm_page // Page
);
    // ==========================================================
    // Helpers
    logic [31:0] busy_cnt;
    wire logic rd_ap = hsel && htrans[1] && !hwrite && hready;
    always_ff @(posedge hclk) busy_cnt <= nvm_busy ? busy_cnt + 32'h1 : 32'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Assertions
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_load_pulse: assert property (ce |-> load_valid == $past(load_instr))
        else $error("load strobe not one cycle after load");
    a_load_hold: assert property (!load_valid |-> $stable(load_data)) else $error("load data moved");
    a_read_idle: assert property (!$past(rd_ap) |-> hrdata == 32'h0) else $error("read data outside data phase");
    a_halt_busy: assert property (nvm_busy |-> cpu_halt)
        else $error("busy without halt");
    a_halt_cause: assert property (cpu_halt |-> nvm_busy || $past(store_instr))
        else $error("halt without store or operation");
    a_halt_leads: assert property ($rose(cpu_halt) |-> ##[0:2] nvm_busy)
        else $error("halt without operation");
    a_busy_cause: assert property ($rose(nvm_busy) |-> $past(store_instr, 2) || $past(store_instr, 3))
        else $error("operation without store");
    a_page_hold: assert property (nvm_busy && $past(nvm_busy) |-> $stable(nvm_page) && $stable(nvm_erase))
        else $error("page changed mid operation");
    a_busy_len: assert property ($fell(nvm_busy) |->
        busy_cnt + 32'h1 >= 32'(PROG_CYCLES) && busy_cnt <= 32'(PROG_CYCLES) + 32'h2)
        else $error("operation length wrong");
    c_prog: cover property ($rose(nvm_busy) && !nvm_erase);
    c_wipe: cover property ($rose(nvm_busy) && nvm_erase);
    c_load: cover property (load_valid);
endmodule : fsp_ctrl_monitor
bind fsp_ctrl fsp_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_fsp_ctrl_monitor (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .store_instr(store_instr), .load_instr(load_instr),
    .load_data(load_data), .load_valid(load_valid), .cpu_halt(cpu_halt), .nvm_busy(nvm_busy),
    .nvm_erase(nvm_erase), .nvm_page(nvm_page));
`default_nettype wire

// ---- fsp_pkg.sv ----
// Purpose: Shared constants and types for the flash self-programming control block
// Assumes: 25 MHz hclk, 16-bit program pointer, 16-bit flash words
// Notes: Offsets are byte addresses on the AHB-Lite register bus

package fsp_pkg;

    // ==========================================================
    // Flash geometry
    // ==========================================================
    localparam int WORD_BITS = 6;
    localparam int PAGE_WORDS = 1 << WORD_BITS;
    localparam int PAGE_W = 15 - WORD_BITS;
    localparam int PTR_W = 16;
    localparam logic [15:0] BUF_ERASED = 16'hffff;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 25;
    localparam int PROG_TIME_MIN_US = 3700;
    localparam int PROG_TIME_MAX_US = 4500;
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(PROG_TIME_MIN_US * CLK_MHZ);
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN = 3'h3;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [5:0] IDX_CTL = 6'h00;
    localparam logic [5:0] IDX_ENG = 6'h01;
    localparam logic [31:0] OFS_CTL = 32'h0000_0000;
    localparam logic [31:0] OFS_ENG = 32'h0000_0004;
    localparam int BIT_SIG = 5;
    localparam int BIT_FUSE_LOCKBYTE_READ = 3;
    localparam int BIT_PAGE_PROGRAM = 2;
    localparam int BIT_PAGE_WIPE = 1;
    localparam int BIT_EN = 0;
    localparam int ENG_PAGE_LSB = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Legal low-six-bit command patterns
    localparam logic [5:0] PAT_SIG = 6'h21;
    localparam logic [5:0] PAT_CLEAR_PAGE_BUFFER = 6'h11;
    localparam logic [5:0] PAT_FUSE_LOCKBYTE_READ = 6'h09;
    localparam logic [5:0] PAT_PROG = 6'h05;
    localparam logic [5:0] PAT_WIPE = 6'h03;
    localparam logic [5:0] PAT_FILL = 6'h01;

    // ==========================================================
    // Pointer decode for fuse, lock and identity row reads
    // ==========================================================
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] Z_ID0 = 16'h0000;
    localparam logic [15:0] Z_CAL = 16'h0001;
    localparam logic [15:0] Z_ID1 = 16'h0002;
    localparam logic [15:0] Z_TOFS = 16'h0003;
    localparam logic [15:0] Z_ID2 = 16'h0004;
    localparam logic [15:0] Z_TGAIN = 16'h0005;
    localparam logic [7:0] RESERVED_BYTE = 8'h00;
    localparam logic [5:0] LOCK_PAD = 6'h3f;

    typedef enum logic [2:0] {
        MODE_IDLE, MODE_FILL, MODE_CLEAR, MODE_FUSE, MODE_SIG, MODE_WIPE, MODE_PROG
    } fsp_mode_e;

    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [5:0] ap_idx;
        logic [31:0] rdata;
        fsp_mode_e mode;
        logic [2:0] win;
        logic waiting;
        logic clr_pend;
        logic ld_valid;
        logic [7:0] ld_data;
        logic start;
        logic start_erase;
        logic [PAGE_W-1:0] start_page;
        logic buf_we;
        logic buf_clr;
        logic [WORD_BITS-1:0] buf_idx;
        logic [15:0] buf_wdata;
    } fsp_core_s;

    typedef struct packed {
        logic busy;
        logic erase;
        logic done;
        logic [CNT_W-1:0] cnt;
        logic [PAGE_W-1:0] page;
        logic [15:0] rd_word;
        logic [PAGE_WORDS-1:0][15:0] buffer;
    } fsp_eng_s;

    localparam fsp_core_s CORE_RST = '{
        ap_valid: 1'b0, ap_write: 1'b0, ap_idx: 6'h00, rdata: 32'h0000_0000,
        mode: MODE_IDLE, win: 3'h0, waiting: 1'b0, clr_pend: 1'b1,
        ld_valid: 1'b0, ld_data: 8'h00, start: 1'b0, start_erase: 1'b0,
        start_page: '0, buf_we: 1'b0, buf_clr: 1'b0, buf_idx: '0, buf_wdata: 16'h0000};

    localparam fsp_eng_s ENG_RST = '{
        busy: 1'b0, erase: 1'b0, done: 1'b0, cnt: '0, page: '0,
        rd_word: BUF_ERASED, buffer: {PAGE_WORDS{BUF_ERASED}}};

endpackage : fsp_pkg
